// >>> core/prt_timer.sv
// reload timer: 8-bit down counter with reload, flag and clock output
// assumes a one-cycle register port from the cpu side and raw pins
// for the event input and the two oscillator clocks
`include "prt_defines.svh"

module prt_timer #(
    parameter int NR_DIV = `PRT_NR_DIV // slow clocks per rejector sample
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [3:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [3:0] rdata_o,
    // raw clock sources
    input wire logic event_input_i,
    input wire logic slow_osc_clock_i,
    input wire logic fast_osc_clock_i,
    // output port path
    input wire logic port_dc_level_i,
    output logic output_pin_o,
    // serial interface and interrupt path
    output logic underflow_clock_o,
    output logic irq_o
);

    localparam logic [6:0] NR_LAST = 7'(NR_DIV - 1);

    prt_pkg::prt_state_type s; // all registered state
    prt_pkg::prt_state_type next_s; // its next value
    prt_pkg::prt_src_type src_sel; // decoded source field
    logic reload_strobe; // software reset of the timer
    logic underflow; // counter reached 00H this cycle
    logic [7:0] dec; // counter minus one

    prt_cnt_if cnt_if ();

    // predivider sits behind the source selector
    prt_prediv u_prediv (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .cnt_if(cnt_if)
    );

    // source selection reads only settled, synchronised levels
    assign src_sel = prt_pkg::prt_src_type'(s.cfg[`PRT_CFG_SRC_LSB +: 2]);
    assign cnt_if.div_sel =
        prt_pkg::prt_div_type'(s.cfg[`PRT_CFG_DIV_LSB +: 2]);
    assign cnt_if.enable = s.run;
    assign cnt_if.clear = reload_strobe;

    // source mux and edge direction
    always_comb begin
        cnt_if.fall_edge = 1'b0;
        unique case (src_sel)
            prt_pkg::PRT_SRC_FILTERED: begin
                cnt_if.src_lvl = s.nr_out;
                cnt_if.fall_edge = 1'b1;
            end
            prt_pkg::PRT_SRC_DIRECT: begin
                cnt_if.src_lvl = s.sync2[0];
                cnt_if.fall_edge = 1'b1;
            end
            prt_pkg::PRT_SRC_SLOW: begin
                cnt_if.src_lvl = s.sync2[1];
            end
            prt_pkg::PRT_SRC_FAST: begin
                cnt_if.src_lvl = s.sync2[2];
            end
        endcase
    end

    // next-state logic for the whole block
    always_comb begin
        next_s = s;
        underflow = 1'b0;
        dec = s.cnt - 8'h01;

        // event and oscillator pins pass two flops before anything reads them
        next_s.sync1 = {fast_osc_clock_i, slow_osc_clock_i, event_input_i};
        next_s.sync2 = s.sync1;
        next_s.slow_prev = s.sync2[1];

        // noise rejector: two equal samples at 256 Hz change the output,
        // so short chatter is dropped and long presses pass
        if (s.sync2[1] && !s.slow_prev) begin
            if (s.nr_cnt == NR_LAST) begin
                next_s.nr_cnt = 7'h00;
                next_s.nr_samp = s.sync2[0];
                if (s.sync2[0] == s.nr_samp) begin
                    next_s.nr_out = s.nr_samp;
                end
            end else begin
                next_s.nr_cnt = s.nr_cnt + 7'h01;
            end
        end

        // software reset: write 1 to the strobe bit, 0 does nothing
        reload_strobe = wr_i && addr_i == `PRT_ADDR_RUN
            && wdata_i[`PRT_BIT_STROBE];

        // register writes; readback and flag addresses ignore them
        if (wr_i) begin
            case (addr_i)
                `PRT_ADDR_MASK: begin
                    next_s.mask = wdata_i[`PRT_BIT_MASK];
                end
                `PRT_ADDR_RUN: begin
                    next_s.run = wdata_i[`PRT_BIT_RUN];
                    next_s.pin_sel = wdata_i[`PRT_BIT_PINSEL];
                end
                `PRT_ADDR_CFG: begin
                    next_s.cfg = wdata_i;
                end
                `PRT_ADDR_RLD_LO: begin
                    next_s.reload[3:0] = wdata_i;
                end
                `PRT_ADDR_RLD_HI: begin
                    next_s.reload[7:4] = wdata_i;
                end
                // counter and flag are read-only
                default: begin
                    next_s.cfg = next_s.cfg;
                end
            endcase
        end

        // register reads: data stand only in the following cycle
        next_s.rdata = 4'h0;
        if (rd_i) begin
            case (addr_i)
                `PRT_ADDR_FLAG: begin
                    next_s.rdata[`PRT_BIT_FLAG] = s.flag;
                    next_s.flag = 1'b0;
                end
                `PRT_ADDR_MASK: begin
                    next_s.rdata[`PRT_BIT_MASK] = s.mask;
                end
                `PRT_ADDR_RUN: begin
                    // strobe bit always reads as zero
                    next_s.rdata[`PRT_BIT_RUN] = s.run;
                    next_s.rdata[`PRT_BIT_PINSEL] = s.pin_sel;
                end
                `PRT_ADDR_CFG: begin
                    next_s.rdata = s.cfg;
                end
                `PRT_ADDR_CNT_LO: begin
                    next_s.rdata = s.cnt[3:0];
                    // keep the high half stable for the next read
                    next_s.hold = s.cnt[7:4];
                end
                `PRT_ADDR_CNT_HI: begin
                    // the high half read is only consistent if the low
                    // half was read first
                    next_s.rdata = s.hold;
                end
                `PRT_ADDR_RLD_LO: begin
                    next_s.rdata = s.reload[3:0];
                end
                `PRT_ADDR_RLD_HI: begin
                    next_s.rdata = s.reload[7:4];
                end
                // unmapped addresses read as zero
                default: begin
                    next_s.rdata = 4'h0;
                end
            endcase
        end

        // down counter; a software reset wins over a count tick
        if (reload_strobe) begin
            next_s.cnt = s.reload;
        end else if (cnt_if.tick) begin
            if (dec == 8'h00) begin
                // reload 00H wraps through FFH, giving 256 counts
                underflow = 1'b1;
                next_s.cnt = s.reload;
                next_s.ovf = !s.ovf;
            end else begin
                next_s.cnt = dec;
            end
        end

        // hardware set wins over the read-clear in the same cycle
        if (underflow) begin
            next_s.flag = 1'b1;
        end

        // registered outputs, from next values to avoid a lag
        next_s.pin = next_s.pin_sel ? !next_s.ovf : port_dc_level_i;
        next_s.irq = next_s.flag && next_s.mask;
    end

    // state register; reload and counter reset to zero though software
    // must treat them as undefined
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
            s.cfg <= `PRT_RST_CFG;
            s.cnt <= `PRT_RST_CNT;
            s.reload <= `PRT_RST_RLD;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flops
    assign rdata_o = s.rdata;
    assign underflow_clock_o = s.ovf;
    assign output_pin_o = s.pin;
    assign irq_o = s.irq;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_sw_reload;
        reload_strobe |=> s.cnt == $past(s.reload);
    endproperty
    a_sw_reload: assert property (p_sw_reload)
        else $error("software reset did not load the reload value");

    property p_cnt_lo_read;
        rd_i && addr_i == `PRT_ADDR_CNT_LO
            |=> rdata_o == $past(s.cnt[3:0]) && s.hold == $past(s.cnt[7:4]);
    endproperty
    a_cnt_lo_read: assert property (p_cnt_lo_read)
        else $error("low counter read or high latch wrong");

    property p_hold_read;
        rd_i && addr_i == `PRT_ADDR_CNT_LO ##1
            rd_i && addr_i == `PRT_ADDR_CNT_HI
            |=> rdata_o == $past(s.cnt[7:4], 2);
    endproperty
    a_hold_read: assert property (p_hold_read)
        else $error("high counter read not from latched half");

    property p_ovf_toggle;
        underflow |=> underflow_clock_o != $past(underflow_clock_o)
            && s.cnt == $past(s.reload);
    endproperty
    a_ovf_toggle: assert property (p_ovf_toggle)
        else $error("underflow did not toggle clock and reload");

    property p_flag_set;
        underflow |=> s.flag ##1 (s.flag || $past(rd_i));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("underflow flag lost");

    property p_irq_gate;
        irq_o == (s.flag && s.mask);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt request not flag and mask");

    property p_flag_clear;
        rd_i && addr_i == `PRT_ADDR_FLAG && !underflow |=> !s.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared by read");

    property p_strobe_reads_zero;
        rd_i && addr_i == `PRT_ADDR_RUN |=> rdata_o[`PRT_BIT_STROBE] == 1'b0;
    endproperty
    a_strobe_reads_zero: assert property (p_strobe_reads_zero)
        else $error("reset bit read back as one");

    property p_stop_holds;
        !s.run && !reload_strobe |=> s.cnt == $past(s.cnt);
    endproperty
    a_stop_holds: assert property (p_stop_holds)
        else $error("counter moved while stopped");

    // the pin keeps its reset level for one edge after release
    property p_pin_route;
        $past(arst_n_i) |-> output_pin_o
            == (s.pin_sel ? !underflow_clock_o : $past(port_dc_level_i));
    endproperty
    a_pin_route: assert property (p_pin_route)
        else $error("output pin route wrong");

    property p_cfg_readback;
        wr_i && addr_i == `PRT_ADDR_CFG ##1 rd_i && addr_i == `PRT_ADDR_CFG
            |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("clock config readback mismatch");

    property p_reload_lo;
        wr_i && addr_i == `PRT_ADDR_RLD_LO
            |=> s.reload[3:0] == $past(wdata_i);
    endproperty
    a_reload_lo: assert property (p_reload_lo)
        else $error("reload low nibble not written");

    property p_reload_hi;
        wr_i && addr_i == `PRT_ADDR_RLD_HI
            |=> s.reload[7:4] == $past(wdata_i);
    endproperty
    a_reload_hi: assert property (p_reload_hi)
        else $error("reload high nibble not written");

    property p_mask_write;
        wr_i && addr_i == `PRT_ADDR_MASK
            |=> s.mask == $past(wdata_i[`PRT_BIT_MASK]);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("interrupt mask not written");

    property p_run_write;
        wr_i && addr_i == `PRT_ADDR_RUN
            |=> s.run == $past(wdata_i[`PRT_BIT_RUN]);
    endproperty
    a_run_write: assert property (p_run_write)
        else $error("run bit not written");

    // a write to the readback addresses must not disturb the counter
    property p_count_ro;
        wr_i && (addr_i == `PRT_ADDR_CNT_LO || addr_i == `PRT_ADDR_CNT_HI)
            && !cnt_if.tick |=> s.cnt == $past(s.cnt);
    endproperty
    a_count_ro: assert property (p_count_ro)
        else $error("counter changed by a write");

    property p_flag_write;
        wr_i && addr_i == `PRT_ADDR_FLAG && !s.flag && !underflow
            |=> !s.flag;
    endproperty
    a_flag_write: assert property (p_flag_write)
        else $error("flag set by a write");

    // a zero count must wrap to FFH, which makes reload 00H count 256
    property p_wrap_256;
        cnt_if.tick && !reload_strobe && s.cnt == 8'h00
            |=> s.cnt == 8'hFF;
    endproperty
    a_wrap_256: assert property (p_wrap_256)
        else $error("zero count did not wrap to FFH");

    property p_count_down;
        cnt_if.tick && !reload_strobe && s.cnt != 8'h01
            |=> s.cnt == $past(s.cnt) - 8'h01;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("counter did not step down by one");

endmodule

// >>> core/prt_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes an 8-bit i/o address and 4-bit data register port
`ifndef PRT_DEFINES_SVH
`define PRT_DEFINES_SVH

// register offsets
`define PRT_ADDR_FLAG 8'hC0
`define PRT_ADDR_MASK 8'hC8
`define PRT_ADDR_RUN 8'hE9
`define PRT_ADDR_CFG 8'hEA
`define PRT_ADDR_CNT_LO 8'hEB
`define PRT_ADDR_CNT_HI 8'hEC
`define PRT_ADDR_RLD_LO 8'hED
`define PRT_ADDR_RLD_HI 8'hEE

// bit positions
`define PRT_BIT_FLAG 0
`define PRT_BIT_MASK 0
`define PRT_BIT_STROBE 0
`define PRT_BIT_RUN 1
`define PRT_BIT_PINSEL 3
`define PRT_CFG_SRC_LSB 0
`define PRT_CFG_DIV_LSB 2

// reset values
`define PRT_RST_CFG 4'h0
`define PRT_RST_CNT 8'h00
`define PRT_RST_RLD 8'h00

// predivider taps for 1/4, 1/32, 1/256
`define PRT_TAP_DIV4 1
`define PRT_TAP_DIV32 4
`define PRT_TAP_DIV256 7

// noise rejector sample rate from the slow oscillator
`define PRT_SLOW_OSC_HZ 32768
`define PRT_NR_SAMPLE_HZ 256
`define PRT_NR_DIV (`PRT_SLOW_OSC_HZ / `PRT_NR_SAMPLE_HZ)

`endif

// >>> core/prt_pkg.sv
// types shared by the reload timer and its predivider
// assumes nothing beyond the defines header
package prt_pkg;

    // count clock sources, in field order
    typedef enum logic [1:0] {
        PRT_SRC_FILTERED,
        PRT_SRC_DIRECT,
        PRT_SRC_SLOW,
        PRT_SRC_FAST
    } prt_src_type;

    // predivider ratios, in field order
    typedef enum logic [1:0] {
        PRT_DIV_256,
        PRT_DIV_32,
        PRT_DIV_4,
        PRT_DIV_1
    } prt_div_type;

    // predivider state
    typedef struct packed {
        logic [7:0] cnt;
        logic src_prev;
        logic div_prev;
    } prt_div_state_type;

    // timer state
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic slow_prev;
        logic [6:0] nr_cnt;
        logic nr_samp;
        logic nr_out;
        logic [3:0] cfg;
        logic run;
        logic pin_sel;
        logic mask;
        logic flag;
        logic [7:0] cnt;
        logic [7:0] reload;
        logic [3:0] hold;
        logic ovf;
        logic pin;
        logic irq;
        logic [3:0] rdata;
    } prt_state_type;

endpackage

// >>> core/prt_cnt_if.sv
// link between the timer core and its predivider
// assumes both ends run on the same clock
interface prt_cnt_if;
    logic src_lvl; // selected source level
    logic fall_edge; // count on falling edge
    prt_pkg::prt_div_type div_sel; // ratio
    logic clear; // restart the divided period
    logic enable; // timer running
    logic tick; // one count of the down counter

    modport ctl (
        output src_lvl, fall_edge, div_sel, clear, enable,
        input tick
    );
    modport div (
        input src_lvl, fall_edge, div_sel, clear, enable,
        output tick
    );
endinterface

// >>> core/prt_prediv.sv
// predivider: divides the selected source and yields count ticks
// assumes src_lvl is already synchronised to sys_clk_i
`include "prt_defines.svh"

module prt_prediv (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // link to the timer core
    prt_cnt_if.div cnt_if
);

    prt_pkg::prt_div_state_type s;
    prt_pkg::prt_div_state_type next_s;
    logic div_lvl; // divided clock level
    logic tick; // edge of divided clock

    // divide, then detect the chosen edge of the divided clock
    always_comb begin
        next_s = s;
        next_s.src_prev = cnt_if.src_lvl;
        if (cnt_if.clear) begin
            next_s.cnt = 8'h00;
        end else if (cnt_if.enable && cnt_if.src_lvl && !s.src_prev) begin
            next_s.cnt = s.cnt + 8'h01;
        end
        unique case (cnt_if.div_sel)
            prt_pkg::PRT_DIV_256: div_lvl = next_s.cnt[`PRT_TAP_DIV256];
            prt_pkg::PRT_DIV_32: div_lvl = next_s.cnt[`PRT_TAP_DIV32];
            prt_pkg::PRT_DIV_4: div_lvl = next_s.cnt[`PRT_TAP_DIV4];
            prt_pkg::PRT_DIV_1: div_lvl = cnt_if.src_lvl;
        endcase
        // rising-edge sources see the tap inverted, so their rising edge
        // lands on the wrap and the first period after a clear is full
        if (cnt_if.div_sel != prt_pkg::PRT_DIV_1 && !cnt_if.fall_edge) begin
            div_lvl = !div_lvl;
        end
        next_s.div_prev = div_lvl;
        // a clear must not count, though it may move the level
        if (cnt_if.clear || !cnt_if.enable) begin
            tick = 1'b0;
        end else if (cnt_if.fall_edge) begin
            tick = s.div_prev && !div_lvl;
        end else begin
            tick = !s.div_prev && div_lvl;
        end
    end

    // state register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cnt_if.tick = tick;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_clear_zero;
        cnt_if.clear |=> s.cnt == 8'h00;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("predivider not cleared by timer reset");

    property p_edge_dir;
        tick |-> (cnt_if.fall_edge ? s.div_prev : !s.div_prev);
    endproperty
    a_edge_dir: assert property (p_edge_dir)
        else $error("count tick on wrong edge of divided clock");

endmodule

// >>> verif/prt_timer_tb_top.sv
// self-checking bench for the reload timer top module
// assumes the core files are compiled first; 100 MHz system clock
`include "prt_defines.svh"

module prt_timer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // clock, reset and register port
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [3:0] wdata_i = 4'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [3:0] rdata_o;
    // sources and outputs
    logic event_input_i = 1'b0;
    logic slow_osc_clock_i = 1'b0;
    logic fast_osc_clock_i = 1'b0;
    logic port_dc_level_i = 1'b0;
    logic output_pin_o;
    logic underflow_clock_o;
    logic irq_o;

    int err_count = 0; // mismatches
    int n_compared = 0; // comparisons made
    integer seed = 32'hDE7E4E0F; // fixed seed
    int src_edges = 0; // source pulses sent
    int last_edges = 0; // pulses at the last toggle
    logic ovf_lvl = 1'b0; // expected overflow clock level
    logic dc_hold = 1'b0; // freeze dc level for a check
    logic dc_val = 1'b0;
    logic rd_d = 1'b0; // read issued last edge
    logic ufc_d = 1'b0; // last seen overflow clock
    logic [3:0] rd_q[$]; // expected read data
    int per_q[$]; // expected pulses per toggle
    logic irq_q[$]; // expected request at toggle

    // small rejector divider keeps filtered pulses short
    prt_timer #(.NR_DIV(2)) dut (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .event_input_i(event_input_i),
        .slow_osc_clock_i(slow_osc_clock_i),
        .fast_osc_clock_i(fast_osc_clock_i),
        .port_dc_level_i(port_dc_level_i),
        .output_pin_o(output_pin_o),
        .underflow_clock_o(underflow_clock_o),
        .irq_o(irq_o)
    );

    // free-running system clock
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // dc level is noise unless a check freezes it
    always @(posedge sys_clk_i) begin
        port_dc_level_i <= dc_hold ? dc_val : 1'($random(seed));
    end

    task automatic chk_data(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_level(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_period(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // watcher: pairs each result with the oldest note
    always @(posedge sys_clk_i) begin
        if (rd_d) begin
            chk_data(rdata_o, rd_q.pop_front());
        end
        // an unexpected toggle meets -1 and fails
        if (arst_n_i && underflow_clock_o !== ufc_d) begin
            chk_period(src_edges - last_edges,
                per_q.size() ? per_q.pop_front() : -1);
            chk_level(irq_o, irq_q.size() ? irq_q.pop_front() : 1'bx);
            last_edges = src_edges;
        end
        ufc_d = underflow_clock_o;
        rd_d = rd_i;
    end

    // one-cycle write strobe
    task automatic reg_wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    // one-cycle read strobe, data noted for the watcher
    task automatic reg_rd(input logic [7:0] a, input logic [3:0] e);
        rd_q.push_back(e);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
    endtask

    // n pulses of 2*half cycles on the chosen source
    task automatic pulses(input int src, input int n, input int half);
        logic lvl;
        for (int i = 0; i < 2 * n * half; i++) begin
            @(posedge sys_clk_i);
            lvl = (i % (2 * half)) < half;
            if (lvl && (i % (2 * half)) == 0) src_edges++;
            case (src)
                0, 1: event_input_i <= lvl;
                2: slow_osc_clock_i <= lvl;
                default: fast_osc_clock_i <= lvl;
            endcase
            // rejector sampling needs the slow clock running
            if (src == 0) slow_osc_clock_i <= (i % 4) < 2;
            // unselected fast clock toggles to catch a wrong select
            if (src != 3) fast_osc_clock_i <= ~fast_osc_clock_i;
        end
    endtask

    // run whole overflow periods, then stop and clear the flag
    task automatic run_periods(input int src, input int dv,
        input logic [7:0] rv, input int ntog, input logic msk,
        input int half);
        int ticks;
        ticks = (rv == 8'h00) ? 256 : int'(rv);
        ticks = ticks * ((dv == 3) ? 1 : (dv == 2) ? 4 : (dv == 1) ? 32 : 256);
        @(posedge sys_clk_i);
        fast_osc_clock_i <= 1'b0;
        reg_wr(`PRT_ADDR_MASK, {3'h0, msk});
        reg_wr(`PRT_ADDR_RLD_LO, rv[3:0]);
        reg_wr(`PRT_ADDR_RLD_HI, rv[7:4]);
        reg_wr(`PRT_ADDR_CFG, {dv[1:0], src[1:0]});
        reg_wr(`PRT_ADDR_RUN, 4'h3);
        last_edges = src_edges;
        for (int k = 0; k < ntog; k++) begin
            per_q.push_back(ticks);
            irq_q.push_back(msk);
            ovf_lvl = ~ovf_lvl;
        end
        pulses(src, ticks * ntog, half);
        repeat (4 * half) @(posedge sys_clk_i);
        reg_wr(`PRT_ADDR_RUN, 4'h0);
        reg_rd(`PRT_ADDR_FLAG, 4'h1);
        reg_rd(`PRT_ADDR_FLAG, 4'h0);
        chk_level(irq_o, 1'b0);
        $display("test periods src=%0d div=%0d done", src, dv);
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog: a few times the expected run length
    initial begin
        repeat (30000) @(posedge sys_clk_i);
        err_count++;
        print_verdict();
    end

    // main sequence
    initial begin
        logic [7:0] rv;
        logic [3:0] cv;
        repeat (20) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        reg_rd(`PRT_ADDR_CFG, 4'h0);
        reg_rd(`PRT_ADDR_RUN, 4'h0);
        reg_rd(`PRT_ADDR_MASK, 4'h0);
        reg_rd(`PRT_ADDR_FLAG, 4'h0);
        reg_rd(8'h55, 4'h0);
        $display("test reset values done");
        // register access and counter readback while stopped
        rv = 8'($random(seed));
        cv = 4'($random(seed));
        reg_wr(`PRT_ADDR_CFG, cv);
        reg_rd(`PRT_ADDR_CFG, cv);
        reg_wr(`PRT_ADDR_FLAG, 4'hF);
        reg_rd(`PRT_ADDR_FLAG, 4'h0);
        reg_wr(`PRT_ADDR_CFG, 4'hF);
        reg_wr(`PRT_ADDR_RLD_HI, rv[7:4]);
        reg_wr(`PRT_ADDR_RLD_LO, rv[3:0]);
        reg_rd(`PRT_ADDR_RLD_LO, rv[3:0]);
        reg_rd(`PRT_ADDR_RLD_HI, rv[7:4]);
        reg_wr(`PRT_ADDR_RUN, 4'h5);
        reg_rd(`PRT_ADDR_RUN, 4'h0);
        reg_wr(`PRT_ADDR_CNT_LO, ~rv[3:0]);
        reg_wr(`PRT_ADDR_CNT_HI, ~rv[7:4]);
        pulses(3, 4, 2);
        reg_rd(`PRT_ADDR_CNT_LO, rv[3:0]);
        reg_wr(`PRT_ADDR_RLD_HI, rv[7:4] ^ 4'h5);
        reg_wr(`PRT_ADDR_RUN, 4'h1);
        reg_rd(`PRT_ADDR_CNT_HI, rv[7:4]);
        reg_rd(`PRT_ADDR_CNT_LO, rv[3:0]);
        reg_rd(`PRT_ADDR_CNT_HI, rv[7:4] ^ 4'h5);
        $display("test readback done");
        // every source and ratio code, masked and unmasked
        run_periods(3, 3, 8'h02, 3, 1'b1, 5);
        run_periods(2, 2, 8'h03, 2, 1'b0, 5);
        run_periods(1, 1, 8'h01, 2, 1'b1, 5);
        run_periods(1, 0, 8'h01, 1, 1'b0, 5);
        run_periods(0, 3, 8'h02, 2, 1'b1, 40);
        run_periods(3, 3, 8'h00, 1, 1'b0, 5);
        // pin routing of the inverted overflow clock and dc level
        dc_hold = 1'b1;
        reg_wr(`PRT_ADDR_RUN, 4'h8);
        reg_rd(`PRT_ADDR_RUN, 4'h8);
        repeat (3) @(posedge sys_clk_i);
        chk_level(underflow_clock_o, ovf_lvl);
        chk_level(output_pin_o, ~ovf_lvl);
        reg_wr(`PRT_ADDR_RUN, 4'h0);
        for (int v = 0; v < 2; v++) begin
            dc_val = v[0];
            repeat (3) @(posedge sys_clk_i);
            chk_level(output_pin_o, v[0]);
        end
        $display("test pin routing done");
        repeat (4) @(posedge sys_clk_i);
        print_verdict();
    end
endmodule
